// file: psl_regs.vh
`ifndef PSL_REGS_VH
`define PSL_REGS_VH

// register offsets, six-bit immediate address space
`define PSL_ADDR_STATUS      6'h13
`define PSL_ADDR_LATCH       6'h14
`define PSL_ADDR_LINE        6'h15
`define PSL_ADDR_SCR_WR      6'h16
`define PSL_ADDR_SCR_SET     6'h17
`define PSL_ADDR_SCR_CLR     6'h18
`define PSL_ADDR_ROUTE_WR    6'h19
`define PSL_ADDR_ROUTE_SET   6'h1a
`define PSL_ADDR_ROUTE_CLR   6'h1b

// source bit positions, shared by status and latch
`define PSL_BIT_ID_GROUNDED  4
`define PSL_BIT_SESS_ENDED   3
`define PSL_BIT_SESS_OK      2
`define PSL_BIT_VBUS_OK      1
`define PSL_BIT_HOST_DISC    0
`define PSL_SRC_W            5

// routing control fields
`define PSL_BIT_RX_ROUTE     3
`define PSL_BIT_TX_ROUTE     2
`define PSL_ROUTE_MASK       8'h0c

// reset values
`define PSL_RST_LATCH        5'h00
`define PSL_RST_SCRATCH      8'h00
`define PSL_RST_ROUTE        8'h00

`endif

// file: psl_status_regs.v
// Notes on behaviour
// - status at 13h shows live source signals
// - status bit 4 shows id grounded
// - bits 3..1 show session and vbus comparators
// - status bit 0 shows host disconnect
// - unmasked source transition sets latch bit at 14h
// - latch bit order mirrors status, upper zero
// - reading latch returns old value then clears
// - entering low power clears all latch bits
// - line state view at 15h, bits 1..0
// - scratch byte at 16h, set 17h, clear 18h
// - scratch byte affects nothing else
// - routing acts only while uart mode set
// - uart active halts ulpi register transfers
// - rx enable routes dp onto data1
// - tx enable routes data0 onto dm
// - leaving uart mode clears both routing enables
// - rising transition counts only when enabled
// - falling transition counts only when enabled
`timescale 1ns/1ps
`default_nettype none
`include "psl_regs.vh"

module psl_status_regs #(
  parameter integer SRC_W = `PSL_SRC_W
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // register access from the ulpi protocol engine
  input  wire             reg_wr,
  input  wire             reg_rd,
  input  wire [5:0]       reg_addr,
  input  wire [7:0]       reg_wdata,
  output reg  [7:0]       reg_rdata,
  output reg              reg_rvalid,
  // edge enables and mode from the neighbouring registers
  input  wire [SRC_W-1:0] rising_edge_enables,
  input  wire [SRC_W-1:0] falling_edge_enables,
  input  wire             uart_mode,
  input  wire             low_power_enter,
  // analog sources, asynchronous
  input  wire             id_grounded,
  input  wire             session_ended,
  input  wire             session_ok,
  input  wire             vbus_ok,
  input  wire             host_disconnected,
  input  wire [1:0]       line_state,
  // uart pins
  input  wire             dp_in,
  input  wire             data0_in,
  output reg              data1_out,
  output wire             data1_oe,
  output reg              dm_out,
  output wire             dm_oe,
  // status towards the protocol engine
  output wire             ulpi_halted,
  output reg  [SRC_W-1:0] event_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  reg rst_s1;
  reg rst_s2;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  wire srst_n = rst_s2;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: three stages, accept when stages two and three agree

  localparam integer SYN_W = SRC_W + 4;

  wire [SYN_W-1:0] raw_in = {data0_in, dp_in, line_state, id_grounded, session_ended,
                             session_ok, vbus_ok, host_disconnected};
  reg  [SYN_W-1:0] syn1;
  reg  [SYN_W-1:0] syn2;
  reg  [SYN_W-1:0] syn3;
  reg  [SYN_W-1:0] stable;

  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      syn1   <= {SYN_W{1'b0}};
      syn2   <= {SYN_W{1'b0}};
      syn3   <= {SYN_W{1'b0}};
      stable <= {SYN_W{1'b0}};
    end else begin
      syn1   <= raw_in;
      syn2   <= syn1;
      syn3   <= syn2;
      // glitch filter: a bit moves only once two samples match
      stable <= (syn2 & syn3) | (stable & (syn2 | syn3));
    end
  end

  wire [SRC_W-1:0] src_now   = stable[SRC_W-1:0];
  wire [1:0]       line_now  = stable[SRC_W+1:SRC_W];
  wire             dp_now    = stable[SRC_W+2];
  wire             data0_now = stable[SRC_W+3];

  ////////////////////////////////////////////////////////////////////////////
  // edge detection and latch

  reg  [SRC_W-1:0] src_prev;
  reg  [SRC_W-1:0] latch;
  reg  [7:0]       scratch;
  reg  [7:0]       route;
  reg              uart_prev;

  wire [SRC_W-1:0] rise_ev = src_now & ~src_prev & rising_edge_enables;
  wire [SRC_W-1:0] fall_ev = ~src_now & src_prev & falling_edge_enables;
  wire [SRC_W-1:0] any_ev  = rise_ev | fall_ev;

  // routing becomes active once the mode bit is set and a route is enabled
  assign ulpi_halted = uart_mode & (route[`PSL_BIT_RX_ROUTE] | route[`PSL_BIT_TX_ROUTE]);

  wire acc_ok  = ~ulpi_halted;
  wire do_rd   = reg_rd & acc_ok;
  wire do_wr   = reg_wr & acc_ok;
  wire rd_latch = do_rd & (reg_addr == `PSL_ADDR_LATCH);

  // set wins: an event in the clearing cycle survives the clear
  reg [SRC_W-1:0] next_latch;

  always @* begin
    next_latch = latch;
    if (rd_latch | low_power_enter) begin
      // the read answer is taken from the old byte in this same cycle
      next_latch = {SRC_W{1'b0}};
    end
    next_latch = next_latch | any_ev;
  end

  function [7:0] psl_alias;
    input [7:0] cur;
    input [7:0] wdat;
    input [1:0] kind;
    begin
      case (kind)
        2'h0:    psl_alias = wdat;
        2'h1:    psl_alias = cur | wdat;
        2'h2:    psl_alias = cur & ~wdat;
        default: psl_alias = cur;
      endcase
    end
  endfunction

  reg [1:0] scr_kind;
  reg [1:0] rte_kind;

  always @* begin
    case (reg_addr)
      `PSL_ADDR_SCR_WR:  scr_kind = 2'h0;
      `PSL_ADDR_SCR_SET: scr_kind = 2'h1;
      `PSL_ADDR_SCR_CLR: scr_kind = 2'h2;
      default:           scr_kind = 2'h3;
    endcase
    case (reg_addr)
      `PSL_ADDR_ROUTE_WR:  rte_kind = 2'h0;
      `PSL_ADDR_ROUTE_SET: rte_kind = 2'h1;
      `PSL_ADDR_ROUTE_CLR: rte_kind = 2'h2;
      default:             rte_kind = 2'h3;
    endcase
  end

  wire uart_exit = uart_prev & ~uart_mode;

  ////////////////////////////////////////////////////////////////////////////
  // next values of the link-writable bytes

  reg [7:0] next_scratch;
  reg [7:0] next_route;

  always @* begin
    next_scratch = scratch;
    if (do_wr) begin
      // scratch is storage only, wired to nothing else
      next_scratch = psl_alias(scratch, reg_wdata, scr_kind);
    end
  end

  always @* begin
    next_route = route;
    if (uart_exit) begin
      // exit clear beats a write landing in the same cycle
      next_route = `PSL_RST_ROUTE;
    end else if (do_wr) begin
      // only the two enables are stored; reserved bits stay zero
      next_route = psl_alias(route, reg_wdata, rte_kind) & `PSL_ROUTE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers

  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      src_prev    <= {SRC_W{1'b0}};
      latch       <= `PSL_RST_LATCH;
      event_pulse <= {SRC_W{1'b0}};
    end else begin
      src_prev    <= src_now;
      latch       <= next_latch;
      event_pulse <= any_ev;
    end
  end

  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      scratch   <= `PSL_RST_SCRATCH;
      route     <= `PSL_RST_ROUTE;
      uart_prev <= 1'b0;
    end else begin
      scratch   <= next_scratch;
      route     <= next_route;
      uart_prev <= uart_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read

  reg [7:0] next_rdata;

  always @* begin
    case (reg_addr)
      `PSL_ADDR_STATUS:    next_rdata = {3'h0, src_now};
      `PSL_ADDR_LATCH:     next_rdata = {3'h0, latch};
      `PSL_ADDR_LINE:      next_rdata = {6'h00, line_now};
      `PSL_ADDR_SCR_WR,
      `PSL_ADDR_SCR_SET,
      `PSL_ADDR_SCR_CLR:   next_rdata = scratch;
      `PSL_ADDR_ROUTE_WR,
      `PSL_ADDR_ROUTE_SET,
      `PSL_ADDR_ROUTE_CLR: next_rdata = route;
      default:             next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      reg_rvalid <= 1'b0;
    end else begin
      // a refused read gets no answer at all
      reg_rvalid <= do_rd;
    end
  end

  // read data holds between answers, only an accepted read reloads it
  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      reg_rdata <= 8'h00;
    end else if (do_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transparent uart routing

  wire rx_on = uart_mode & route[`PSL_BIT_RX_ROUTE];
  wire tx_on = uart_mode & route[`PSL_BIT_TX_ROUTE];

  assign data1_oe = rx_on;
  assign dm_oe    = tx_on;

  // three-stage sampling adds latency, harmless at uart bit rates
  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      data1_out <= 1'b0;
    end else begin
      data1_out <= rx_on & dp_now;
    end
  end

  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      dm_out <= 1'b0;
    end else begin
      // a disabled route parks the pin low rather than passing noise
      dm_out <= tx_on ? data0_now : 1'b0;
    end
  end

endmodule // psl_status_regs

`default_nettype wire

// file: psl_status_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module psl_status_regs_properties #(
  parameter integer SRC_W = 5
) (
  // clock, reset and bus
  input wire logic             clk, rst_n, reg_rd, uart_mode, low_power_enter,
  input wire logic [5:0]       reg_addr,
  input wire logic [7:0]       reg_rdata,
  // answers and routing
  input wire logic             reg_rvalid, data1_oe, dm_oe, ulpi_halted,
  input wire logic [SRC_W-1:0] event_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rd_ok = reg_rd && !ulpi_halted;
  wire rd_l  = rd_ok && reg_addr == 6'h14;
  property p_rv; rd_ok |=> reg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_norv; !rd_ok |=> !reg_rvalid; endproperty
  a_norv: assert property (p_norv) else $error("answer without read");
  property p_oe; (data1_oe || dm_oe) |-> uart_mode && ulpi_halted; endproperty
  a_oe: assert property (p_oe) else $error("route active outside uart");
  property p_rdclr; rd_l ##1 (rd_l && event_pulse == 0) |=> reg_rdata == 8'h00; endproperty
  a_rdclr: assert property (p_rdclr) else $error("latch kept after read");
  property p_lp; low_power_enter ##1 (rd_l && event_pulse == 0) |=> reg_rdata == 8'h00;
  endproperty
  a_lp: assert property (p_lp) else $error("latch kept after low power");
  property p_up; rd_ok && reg_addr inside {6'h13, 6'h14} |=> reg_rdata[7:5] == 3'h0;
  endproperty
  a_up: assert property (p_up) else $error("upper source bits set");
  property p_ln; rd_ok && reg_addr == 6'h15 |=> reg_rdata[7:2] == 6'h00; endproperty
  a_ln: assert property (p_ln) else $error("line view upper bits set");
  property p_ex; $fell(uart_mode) |=> !data1_oe && !dm_oe; endproperty
  a_ex: assert property (p_ex) else $error("route kept after uart exit");
  c_rdclr: cover property (rd_l ##1 rd_l);
  c_halt: cover property (ulpi_halted);
  c_evt: cover property (event_pulse != 0);
endmodule // psl_status_regs_properties
`default_nettype wire

// file: psl_uart_peer.sv
`timescale 1ns/1ps
`default_nettype none
module psl_uart_peer (
  input wire logic en,
  output var logic dp
);
  // uart line idles high on its pull-up between frames
  initial dp = 1'b1;
  always #100 dp = en ? ~dp : 1'b1;
endmodule // psl_uart_peer
`default_nettype wire

// file: test_ulpi_phy_status_latch_uart_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_ulpi_phy_status_latch_uart_regs;
  logic       clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, uart_mode = 0, lpe = 0, data0_in = 0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, sc, b, q[$], qe[$];
  logic [4:0] re = 5'h1f, fe = 5'h1f, src = 5'h00, r, ev;
  logic [1:0] ls = 2'h0;
  logic       reg_rvalid, d1, d1oe, dm, dmoe, halted, dp, p;
  int         n_fail = 0, compares = 0, n;
  always #12.5 clk = ~clk;
  psl_status_regs u_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .rising_edge_enables(re), .falling_edge_enables(fe), .uart_mode(uart_mode),
    .low_power_enter(lpe), .id_grounded(src[4]), .session_ended(src[3]), .session_ok(src[2]),
    .vbus_ok(src[1]), .host_disconnected(src[0]), .line_state(ls), .dp_in(dp),
    .data0_in(data0_in), .data1_out(d1), .data1_oe(d1oe), .dm_out(dm), .dm_oe(dmoe),
    .ulpi_halted(halted), .event_pulse(ev));
  psl_uart_peer u_peer (.en(d1oe), .dp(dp));
  task automatic chk(input string nm, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    reg_wr <= 0; reg_rd <= 1; reg_addr <= a; q.push_back(e); @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_rd <= 0; reg_wr <= 1; reg_addr <= a; reg_wdata <= d; @(posedge clk);
  endtask
  task automatic idle(input int c);
    reg_rd <= 0; reg_wr <= 0; repeat (c) @(posedge clk);
  endtask
  // sources pass a synchroniser and filter before they count
  task automatic put(input logic [4:0] v);
    logic [4:0] o, e;
    o = src;
    src <= v;
    idle(1);
    e = (v & ~o & re) | (~v & o & fe);
    if (e != 5'h00) qe.push_back({3'h0, e});
    idle(7);
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(negedge clk) if (reg_rvalid === 1'b1) begin
    if (q.size() == 0) chk("rvalid", 8'h00, 8'hff);
    else chk("rdata", q.pop_front(), reg_rdata);
  end
  always @(negedge clk) if (ev !== 5'h00) begin
    if (qe.size() == 0) chk("event", 8'h00, {3'h0, ev});
    else chk("event", qe.pop_front(), {3'h0, ev});
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    void'($urandom(47));
    rd(6'h14, 8'h00);
    rd(6'h16, 8'h00);
    rd(6'h19, 8'h00);
    rd(6'h20, 8'h00);
    r = 5'($urandom) | 5'h01;
    ls <= 2'($urandom);
    put(r);
    rd(6'h13, {3'h0, r});
    rd(6'h15, {6'h00, ls});
    rd(6'h14, {3'h0, r});
    rd(6'h14, 8'h00);
    fe <= 5'h00;
    put(5'h00);
    rd(6'h14, 8'h00);
    fe <= 5'h1f;
    re <= 5'h00;
    put(r);
    rd(6'h14, 8'h00);
    put(5'h00);
    rd(6'h14, {3'h0, r});
    re <= 5'h1f;
    put(r);
    lpe <= 1;
    @(posedge clk);
    lpe <= 0;
    rd(6'h14, 8'h00);
    sc = 8'($urandom);
    b = 8'($urandom);
    wr(6'h16, sc);
    rd(6'h16, sc);
    wr(6'h17, b);
    rd(6'h16, sc | b);
    wr(6'h18, sc);
    rd(6'h16, b & ~sc);
    rd(6'h13, {3'h0, r});
    wr(6'h19, 8'h0c);
    idle(1);
    @(negedge clk);
    chk("oe", 8'h00, {6'h00, d1oe, dmoe});
    @(posedge clk);
    rd(6'h19, 8'h0c);
    wr(6'h1b, 8'h0c);
    uart_mode <= 1;
    idle(1);
    wr(6'h19, 8'h0c);
    reg_rd <= 1; // answer must not come
    reg_addr <= 6'h14;
    @(posedge clk);
    wr(6'h16, ~sc);
    data0_in <= 1;
    idle(8);
    @(negedge clk);
    chk("uart", 8'h0f, {4'h0, halted, d1oe, dmoe, dm});
    n = 0;
    repeat (64) begin
      p = d1;
      @(negedge clk);
      if (d1 !== p) n++;
    end
    @(posedge clk);
    chk("rx edges", 8'h01, 8'(n >= 14));
    uart_mode <= 0;
    idle(1);
    uart_mode <= 1;
    @(negedge clk);
    chk("oe", 8'h00, {6'h00, d1oe, dmoe});
    @(posedge clk);
    uart_mode <= 0;
    rd(6'h19, 8'h00);
    rd(6'h16, (sc | b) & ~sc);
    idle(1);
    for (n = 0; n < 20 && (q.size() != 0 || qe.size() != 0); n++) @(posedge clk);
    if (q.size() != 0 || qe.size() != 0) chk("pending", 8'h00, 8'hff);
    tally_and_finish();
  end
endmodule // test_ulpi_phy_status_latch_uart_regs
bind psl_status_regs psl_status_regs_properties #(.SRC_W(SRC_W)) u_chk (.clk(clk),
  .rst_n(rst_n), .reg_rd(reg_rd), .uart_mode(uart_mode), .low_power_enter(low_power_enter),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .data1_oe(data1_oe),
  .dm_oe(dm_oe), .ulpi_halted(ulpi_halted), .event_pulse(event_pulse));
`default_nettype wire
